// ==== verilog/touch_tune_pkg.sv ====
// constants and types shared by the touch tuning and click sounder design
package touch_tune_pkg;
  // register addresses
  localparam logic [7:0] REG_THRESHOLD = 8'h04;
  localparam logic [7:0] REG_SOUNDER = 8'h07;
  localparam logic [7:0] REG_HELD = 8'h09;
  localparam logic [7:0] REG_VERSION = 8'h0b;
  // bus slave address, arbitrary default
  localparam logic [6:0] DEV_ADDR = 7'h4c;
  // reset values and read data of unmapped addresses
  localparam logic [7:0] THRESHOLD_RST = 8'h0f;
  localparam logic [7:0] HELD_RST = 8'h00;
  localparam logic [7:0] SOUNDER_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // threshold range and clamp value
  localparam logic [7:0] THRESHOLD_MAX = 8'h3f;
  localparam logic [7:0] THRESHOLD_CLAMP = 8'h3f;
  // samples per timeout unit and last count of the recalibration period
  localparam logic [14:0] SAMPLES_PER_UNIT = 15'h0040;
  localparam logic [5:0] RECAL_LAST = 6'h3f;
  // sounder field positions
  localparam int SND_LEN_BIT = 2;
  localparam int SND_PITCH_BIT = 1;
  localparam int SND_EN_BIT = 0;
  // timing
  localparam int CLK_HZ = 100000000;
  localparam int CLICK_SHORT_US = 10000;
  localparam int CLICK_LONG_US = 20000;
  localparam int CLICK_SHORT_CYC = CLICK_SHORT_US * (CLK_HZ / 1000000);
  localparam int CLICK_LONG_CYC = CLICK_LONG_US * (CLK_HZ / 1000000);
  localparam int TONE_LOW_HZ = 1000;
  localparam int TONE_HIGH_HZ = 2000;
  localparam int TONE_LOW_HALF_CYC = CLK_HZ / (2 * TONE_LOW_HZ);
  localparam int TONE_HIGH_HALF_CYC = CLK_HZ / (2 * TONE_HIGH_HZ);
  // version text, arbitrary content
  localparam int DESC_LEN = 30;
  localparam logic [DESC_LEN*8-1:0] DESC_TEXT =
    "XYZ,PN:TOUCH8,QUAL:ENG,VER:1_0";
  localparam logic [4:0] DESC_END = 5'd30;

  typedef struct packed {
    logic [4:0] reserved;
    logic click_length_sel;
    logic tone_pitch_sel;
    logic buzzer_on;
  } sounder_cfg_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PACK = 9'h010,
    ST_WDAT = 9'h020,
    ST_WACK = 9'h040,
    ST_RDAT = 9'h080,
    ST_RACK = 9'h100
  } bus_state_t;
endpackage

// ==== verilog/held_touch_timer.sv ====
// held touch timer: counts samples of a persisting touch up to the timeout
`timescale 1ns/1ps
`default_nettype none
module held_touch_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sample_tick,
  input wire logic touch_active,
  input wire logic [7:0] held_touch_factor,
  output logic expire
);
  logic [14:0] cnt_ff;
  logic [14:0] nxt_cnt;
  logic expire_ff;
  logic nxt_expire;
  logic [14:0] limit;

  always_comb begin
    // factor n gives n+1 units of 64 samples
    limit = {1'b0, held_touch_factor, 6'h00} +
      touch_tune_pkg::SAMPLES_PER_UNIT;
    nxt_cnt = cnt_ff;
    nxt_expire = 1'b0;
    if (!touch_active || held_touch_factor == 8'h00) begin
      nxt_cnt = 15'h0000;
    end else if (sample_tick) begin
      if (cnt_ff == limit - 15'h0001) begin
        nxt_cnt = 15'h0000;
        nxt_expire = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_ff <= 15'h0000;
      expire_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      expire_ff <= nxt_expire;
    end
  end

  assign expire = expire_ff;
endmodule
`default_nettype wire

// ==== verilog/click_tone_gen.sv ====
// key click tone generator driving the piezo output
`timescale 1ns/1ps
`default_nettype none
module click_tone_gen #(
  parameter int CLICK_SHORT_CYC = touch_tune_pkg::CLICK_SHORT_CYC,
  parameter int CLICK_LONG_CYC = touch_tune_pkg::CLICK_LONG_CYC,
  parameter int TONE_LOW_HALF_CYC = touch_tune_pkg::TONE_LOW_HALF_CYC,
  parameter int TONE_HIGH_HALF_CYC = touch_tune_pkg::TONE_HIGH_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic click_length_sel,
  input wire logic tone_pitch_sel,
  output logic buzzer_out,
  output logic busy
);
  logic busy_ff, nxt_busy;
  logic out_ff, nxt_out;
  logic pitch_ff, nxt_pitch;
  logic [21:0] dur_ff, nxt_dur;
  logic [21:0] half_ff, nxt_half;
  logic [21:0] half_load;

  always_comb begin
    nxt_busy = busy_ff;
    nxt_out = out_ff;
    nxt_pitch = pitch_ff;
    nxt_dur = dur_ff;
    nxt_half = half_ff;
    half_load = pitch_ff ? 22'(TONE_HIGH_HALF_CYC - 1) :
      22'(TONE_LOW_HALF_CYC - 1);
    if (!busy_ff) begin
      nxt_out = 1'b0;
      if (start) begin
        nxt_busy = 1'b1;
        nxt_out = 1'b1;
        nxt_pitch = tone_pitch_sel;
        nxt_dur = click_length_sel ? 22'(CLICK_LONG_CYC - 1) :
          22'(CLICK_SHORT_CYC - 1);
        nxt_half = tone_pitch_sel ? 22'(TONE_HIGH_HALF_CYC - 1) :
          22'(TONE_LOW_HALF_CYC - 1);
      end
    end else if (dur_ff == 22'h000000) begin
      nxt_busy = 1'b0;
      nxt_out = 1'b0;
    end else begin
      nxt_dur = dur_ff - 22'h000001;
      if (half_ff == 22'h000000) begin
        nxt_half = half_load;
        nxt_out = ~out_ff;
      end else begin
        nxt_half = half_ff - 22'h000001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_ff <= 1'b0;
      out_ff <= 1'b0;
      pitch_ff <= 1'b0;
      dur_ff <= 22'h000000;
      half_ff <= 22'h000000;
    end else begin
      busy_ff <= nxt_busy;
      out_ff <= nxt_out;
      pitch_ff <= nxt_pitch;
      dur_ff <= nxt_dur;
      half_ff <= nxt_half;
    end
  end

  assign buzzer_out = out_ff;
  assign busy = busy_ff;
endmodule
`default_nettype wire

// ==== verilog/touch_tuning_and_click_sounder.sv ====
// touch tuning, held touch recalibration, click sounder and register slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - held touch timeout is factor times tick times sample period times 64
// - timeout factor field zero disables held touch detection
// - nonzero factor field n selects factor n plus one
// - with detection off a touch stays reported and never joins baseline
// - touch outlasting timeout is folded into baseline and no longer reported
// - timeout factor register sits at address 0x09, read and write
// - threshold writes outside 0 to 63 are replaced by 0x3f
// - threshold encoding n selects sensitivity level n plus one
// - threshold register sits at address 0x04
// - sounder bit 2 selects 10 ms or 20 ms click
// - sounder bit 1 selects 1 kHz or 2 kHz tone
// - sounder bit 0 enables the sounder output
// - click output runs on its own regardless of bus activity
// - sounder configuration register sits at address 0x07
// - read-only version descriptor sits at address 0x0b
// - burst reads return the ascii version text ending in a null
// - periodic auto recalibration is skipped while a touch is detected
module touch_tuning_and_click_sounder #(
  parameter int CLICK_SHORT_CYC = touch_tune_pkg::CLICK_SHORT_CYC,
  parameter int CLICK_LONG_CYC = touch_tune_pkg::CLICK_LONG_CYC,
  parameter int TONE_LOW_HALF_CYC = touch_tune_pkg::TONE_LOW_HALF_CYC,
  parameter int TONE_HIGH_HALF_CYC = touch_tune_pkg::TONE_HIGH_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sample_tick,
  input wire logic [15:0] electrode_value,
  input wire logic auto_recal_on,
  output logic touch_out,
  output logic [15:0] baseline_out,
  output logic buzzer_out
);
  // bus slave and register state
  touch_tune_pkg::bus_state_t state_ff, nxt_state;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [4:0] desc_idx_ff, nxt_desc_idx;
  logic rw_ff, nxt_rw;
  logic ack_ff, nxt_ack;
  logic oe_ff, nxt_oe;
  logic scl_prev_ff, sda_prev_ff;
  logic [7:0] thresh_ff, nxt_thresh;
  logic [7:0] held_ff, nxt_held;
  touch_tune_pkg::sounder_cfg_t snd_ff, nxt_snd;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0] rd_byte;
  logic [7:0] desc_byte;
  // touch state
  logic [15:0] base_ff, nxt_base;
  logic base_valid_ff, nxt_base_valid;
  logic absorbed_ff, nxt_absorbed;
  logic touched_ff, nxt_touched;
  logic [5:0] recal_cnt_ff, nxt_recal_cnt;
  logic [15:0] level;
  logic [15:0] diff;
  logic raw_touch;
  logic expire;
  logic click_start;
  logic recal_due;

  assign scl_rise = scl_in & ~scl_prev_ff;
  assign scl_fall = ~scl_in & scl_prev_ff;
  assign bus_start = scl_in & scl_prev_ff & sda_prev_ff & ~sda_in;
  assign bus_stop = scl_in & scl_prev_ff & ~sda_prev_ff & sda_in;

  // version text byte, null once past the end
  always_comb begin
    desc_byte = 8'h00;
    if (desc_idx_ff < touch_tune_pkg::DESC_END) begin
      desc_byte = touch_tune_pkg::DESC_TEXT[
        (touch_tune_pkg::DESC_LEN - 1 - int'(desc_idx_ff)) * 8 +: 8];
    end
  end

  // read data selection
  always_comb begin
    unique case (ptr_ff)
      touch_tune_pkg::REG_THRESHOLD: rd_byte = thresh_ff;
      touch_tune_pkg::REG_SOUNDER: rd_byte = snd_ff;
      touch_tune_pkg::REG_HELD: rd_byte = held_ff;
      touch_tune_pkg::REG_VERSION: rd_byte = desc_byte;
      default: rd_byte = touch_tune_pkg::UNMAPPED_DATA;
    endcase
  end

  // bus slave and register writes
  always_comb begin
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_desc_idx = desc_idx_ff;
    nxt_rw = rw_ff;
    nxt_ack = ack_ff;
    nxt_oe = oe_ff;
    nxt_thresh = thresh_ff;
    nxt_held = held_ff;
    nxt_snd = snd_ff;
    if (bus_start) begin
      nxt_state = touch_tune_pkg::ST_ADDR;
      nxt_bitcnt = 4'h0;
      nxt_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_state = touch_tune_pkg::ST_IDLE;
      nxt_oe = 1'b0;
    end else begin
      unique case (state_ff)
        touch_tune_pkg::ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        touch_tune_pkg::ST_ADDR, touch_tune_pkg::ST_PTR,
        touch_tune_pkg::ST_WDAT: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_in};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end else if (scl_fall && bitcnt_ff == 4'h8) begin
            nxt_oe = 1'b1;
            if (state_ff == touch_tune_pkg::ST_ADDR) begin
              if (shift_ff[7:1] == touch_tune_pkg::DEV_ADDR) begin
                nxt_state = touch_tune_pkg::ST_AACK;
                nxt_rw = shift_ff[0];
              end else begin
                nxt_state = touch_tune_pkg::ST_IDLE;
                nxt_oe = 1'b0;
              end
            end else if (state_ff == touch_tune_pkg::ST_PTR) begin
              nxt_state = touch_tune_pkg::ST_PACK;
              nxt_ptr = shift_ff;
              nxt_desc_idx = 5'd0;
            end else begin
              nxt_state = touch_tune_pkg::ST_WACK;
              unique case (ptr_ff)
                touch_tune_pkg::REG_THRESHOLD: begin
                  nxt_thresh = (shift_ff > touch_tune_pkg::THRESHOLD_MAX) ?
                    touch_tune_pkg::THRESHOLD_CLAMP : shift_ff;
                end
                touch_tune_pkg::REG_SOUNDER: begin
                  nxt_snd = {5'h00, shift_ff[2:0]};
                end
                touch_tune_pkg::REG_HELD: begin
                  nxt_held = shift_ff;
                end
                default: begin
                  nxt_held = held_ff;
                end
              endcase
              if (ptr_ff == touch_tune_pkg::REG_VERSION) begin
                nxt_desc_idx = desc_idx_ff;
              end else begin
                nxt_ptr = ptr_ff + 8'h01;
              end
            end
          end
        end
        touch_tune_pkg::ST_AACK: begin
          if (scl_fall) begin
            nxt_bitcnt = 4'h0;
            if (rw_ff) begin
              nxt_state = touch_tune_pkg::ST_RDAT;
              nxt_shift = rd_byte;
              nxt_oe = ~rd_byte[7];
            end else begin
              nxt_state = touch_tune_pkg::ST_PTR;
              nxt_oe = 1'b0;
            end
          end
        end
        touch_tune_pkg::ST_PACK, touch_tune_pkg::ST_WACK: begin
          if (scl_fall) begin
            nxt_state = touch_tune_pkg::ST_WDAT;
            nxt_bitcnt = 4'h0;
            nxt_oe = 1'b0;
          end
        end
        touch_tune_pkg::ST_RDAT: begin
          if (scl_rise) begin
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_ff == 4'h8) begin
              nxt_state = touch_tune_pkg::ST_RACK;
              nxt_oe = 1'b0;
              if (ptr_ff == touch_tune_pkg::REG_VERSION) begin
                if (desc_idx_ff != touch_tune_pkg::DESC_END) begin
                  nxt_desc_idx = desc_idx_ff + 5'd1;
                end
              end else begin
                nxt_ptr = ptr_ff + 8'h01;
              end
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe = ~shift_ff[6];
            end
          end
        end
        touch_tune_pkg::ST_RACK: begin
          if (scl_rise) begin
            nxt_ack = ~sda_in;
          end else if (scl_fall) begin
            nxt_bitcnt = 4'h0;
            if (ack_ff) begin
              nxt_state = touch_tune_pkg::ST_RDAT;
              nxt_shift = rd_byte;
              nxt_oe = ~rd_byte[7];
            end else begin
              nxt_state = touch_tune_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= touch_tune_pkg::ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      desc_idx_ff <= 5'd0;
      rw_ff <= 1'b0;
      ack_ff <= 1'b0;
      oe_ff <= 1'b0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      thresh_ff <= touch_tune_pkg::THRESHOLD_RST;
      held_ff <= touch_tune_pkg::HELD_RST;
      snd_ff <= touch_tune_pkg::SOUNDER_RST;
    end else begin
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      desc_idx_ff <= nxt_desc_idx;
      rw_ff <= nxt_rw;
      ack_ff <= nxt_ack;
      oe_ff <= nxt_oe;
      scl_prev_ff <= scl_in;
      sda_prev_ff <= sda_in;
      thresh_ff <= nxt_thresh;
      held_ff <= nxt_held;
      snd_ff <= nxt_snd;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;

  // touch detection against baseline
  always_comb begin
    level = {8'h00, thresh_ff} + 16'h0001;
    diff = base_ff - electrode_value;
    raw_touch = base_valid_ff && (base_ff > electrode_value) &&
      (diff >= level);
    recal_due = sample_tick && recal_cnt_ff == touch_tune_pkg::RECAL_LAST &&
      auto_recal_on && !raw_touch;
    nxt_recal_cnt = sample_tick ? recal_cnt_ff + 6'h01 : recal_cnt_ff;
    nxt_base = base_ff;
    nxt_base_valid = base_valid_ff;
    if (sample_tick && !base_valid_ff) begin
      nxt_base = electrode_value;
      nxt_base_valid = 1'b1;
    end else if (expire) begin
      nxt_base = electrode_value;
    end else if (recal_due) begin
      nxt_base = electrode_value;
    end
    // expiry wins over release in the same cycle
    nxt_absorbed = expire | (absorbed_ff & raw_touch);
    nxt_touched = raw_touch & ~absorbed_ff & ~expire;
    click_start = nxt_touched & ~touched_ff & snd_ff.buzzer_on;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_ff <= 16'h0000;
      base_valid_ff <= 1'b0;
      absorbed_ff <= 1'b0;
      touched_ff <= 1'b0;
      recal_cnt_ff <= 6'h00;
    end else begin
      base_ff <= nxt_base;
      base_valid_ff <= nxt_base_valid;
      absorbed_ff <= nxt_absorbed;
      touched_ff <= nxt_touched;
      recal_cnt_ff <= nxt_recal_cnt;
    end
  end

  assign touch_out = touched_ff;
  assign baseline_out = base_ff;

  held_touch_timer u_held (
    .clk_sys(clk_sys),
    .rst(rst),
    .sample_tick(sample_tick),
    .touch_active(raw_touch & ~absorbed_ff),
    .held_touch_factor(held_ff),
    .expire(expire)
  );

  // sounder is driven by touch events only, never by bus traffic
  click_tone_gen #(
    .CLICK_SHORT_CYC(CLICK_SHORT_CYC),
    .CLICK_LONG_CYC(CLICK_LONG_CYC),
    .TONE_LOW_HALF_CYC(TONE_LOW_HALF_CYC),
    .TONE_HIGH_HALF_CYC(TONE_HIGH_HALF_CYC)
  ) u_click (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(click_start),
    .click_length_sel(snd_ff.click_length_sel),
    .tone_pitch_sel(snd_ff.tone_pitch_sel),
    .buzzer_out(buzzer_out),
    .busy()
  );
endmodule
`default_nettype wire

// ==== bench/touch_tune_chk.sv ====
// port checker for the touch tuning and click sounder block
`timescale 1ns/1ps
`default_nettype none
module touch_tune_chk #(
  parameter int TONE_LOW_HALF_CYC = 10,
  parameter int TONE_HIGH_HALF_CYC = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [15:0] electrode_value,
  input wire logic touch_out,
  input wire logic [15:0] baseline_out,
  input wire logic buzzer_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] hi_ff, lo_ff, nxt_hi, nxt_lo;
  logic no_drop;
  assign no_drop = baseline_out <= electrode_value;
  // run lengths of high and low buzzer phases
  always_comb begin
    nxt_hi = (buzzer_out && !rst) ? hi_ff + 16'h0001 : 16'h0000;
    nxt_lo = (buzzer_out || rst) ? 16'h0000 : lo_ff + {15'h0000, ~&lo_ff};
  end
  always_ff @(posedge clk_sys) begin
    hi_ff <= nxt_hi;
    lo_ff <= nxt_lo;
  end
  AST_SDA_LOW: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |->
    !scl_in && !$past(scl_in))
    else $error("data enable moved while bus clock high");
  AST_HALF_MAX: assert property (hi_ff <= TONE_LOW_HALF_CYC)
    else $error("tone high phase too long");
  AST_HALF_EXACT: assert property ($fell(buzzer_out) |->
    hi_ff == TONE_LOW_HALF_CYC || hi_ff == TONE_HIGH_HALF_CYC)
    else $error("tone high phase length wrong");
  AST_CLICK_START: assert property ($rose(buzzer_out) &&
    lo_ff > TONE_LOW_HALF_CYC |-> $rose(touch_out))
    else $error("click started without new touch");
  AST_NO_TOUCH: assert property ($past(no_drop) |-> !touch_out)
    else $error("touch reported without drop below baseline");
  AST_BASE_LOAD: assert property ($changed(baseline_out) |->
    baseline_out == $past(electrode_value))
    else $error("baseline not loaded from electrode");
  AST_BASE_HOLD: assert property ($changed(baseline_out) &&
    $past(touch_out) |-> !touch_out)
    else $error("baseline moved under a reported touch");
  COV_CLICK: cover property ($rose(buzzer_out));
  COV_EXPIRE: cover property ($fell(touch_out) && $changed(baseline_out));
  COV_ACK: cover property ($rose(sda_oe));
endmodule
bind touch_tuning_and_click_sounder touch_tune_chk #(
  .TONE_LOW_HALF_CYC(TONE_LOW_HALF_CYC),
  .TONE_HIGH_HALF_CYC(TONE_HIGH_HALF_CYC)
) touch_tune_chk_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .electrode_value(electrode_value),
  .touch_out(touch_out),
  .baseline_out(baseline_out),
  .buzzer_out(buzzer_out)
);
`default_nettype wire

// ==== bench/i2c_host_model.sv ====
// bus host model acting as master of the register slave
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_m
);
  logic x;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hw;
    repeat (4) @(posedge clk_sys);
  endtask
  // data set while clock low, sampled as the clock falls
  task automatic bit_io(input logic b, output logic r);
    hw;
    sda_m <= b;
    hw;
    scl <= 1'b1;
    hw;
    r = sda_line;
    scl <= 1'b0;
  endtask
  task automatic start;
    hw;
    sda_m <= 1'b1;
    hw;
    scl <= 1'b1;
    hw;
    sda_m <= 1'b0;
    hw;
    scl <= 1'b0;
  endtask
  task automatic stop;
    hw;
    sda_m <= 1'b0;
    hw;
    scl <= 1'b1;
    hw;
    sda_m <= 1'b1;
    hw;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_io(b[i], x);
    bit_io(1'b1, x);
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, x);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    start;
    send({touch_tune_pkg::DEV_ADDR, 1'b0});
    send(r);
    send(d);
    stop;
  endtask
  task automatic rd_open(input logic [7:0] r);
    start;
    send({touch_tune_pkg::DEV_ADDR, 1'b0});
    send(r);
    start;
    send({touch_tune_pkg::DEV_ADDR, 1'b1});
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    rd_open(r);
    recv(1'b1, d);
    stop;
  endtask
endmodule
`default_nettype wire

// ==== bench/touch_tuning_and_click_sounder_tb.sv ====
// self-checking bench for touch tuning and click sounder
`timescale 1ns/1ps
`default_nettype none
module touch_tuning_and_click_sounder_tb;
  localparam int SHORT = 200;
  localparam int LONG = 400;
  localparam int LOWH = 10;
  localparam int HIGHH = 5;
  localparam int DL = touch_tune_pkg::DESC_LEN;
  localparam logic [DL*8-1:0] TXT = touch_tune_pkg::DESC_TEXT;
  localparam logic [15:0] BASE = 16'h1000;
  logic clk_sys, rst, scl, sda_m, sda_line, sda_out, sda_oe, bp;
  logic sample_tick, auto_recal_on, touch_out, buzzer_out;
  logic [15:0] electrode_value, baseline_out;
  logic [7:0] rd, ex;
  logic [7:0] ra[4] = '{8'h04, 8'h07, 8'h09, 8'h0c};
  logic [7:0] rv[4] = '{8'h0f, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv[5] = '{8'h00, 8'h3f, 8'h40, 8'hff, 8'h0f};
  logic [7:0] sv[5] = '{8'h00, 8'h3f, 8'h3f, 8'h3f, 8'h0f};
  int num_errors = 0;
  int checks = 0;
  int n, e;
  assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
  i2c_host_model host_i (.clk_sys(clk_sys), .sda_line(sda_line),
    .scl(scl), .sda_m(sda_m));
  touch_tuning_and_click_sounder #(.CLICK_SHORT_CYC(SHORT),
    .CLICK_LONG_CYC(LONG), .TONE_LOW_HALF_CYC(LOWH),
    .TONE_HIGH_HALF_CYC(HIGHH)) touch_tuning_and_click_sounder_i (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .sample_tick(sample_tick),
    .electrode_value(electrode_value), .auto_recal_on(auto_recal_on),
    .touch_out(touch_out), .baseline_out(baseline_out),
    .buzzer_out(buzzer_out));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic drive_e(input logic [15:0] v);
    @(posedge clk_sys);
    electrode_value <= v;
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      sample_tick <= 1'b1;
      @(posedge clk_sys);
      sample_tick <= 1'b0;
    end
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    rst = 1'b1;
    sample_tick = 1'b0;
    auto_recal_on = 1'b0;
    electrode_value = BASE;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    tick(1);
    cyc(3);
    cmp(baseline_out, BASE);
    for (int i = 0; i < 4; i++) begin
      host_i.rd(ra[i], rd);
      cmp(rd, rv[i]);
    end
    // stored threshold and its touch boundary
    for (int i = 0; i < 5; i++) begin
      host_i.wr(8'h04, wv[i]);
      host_i.rd(8'h04, rd);
      cmp(rd, sv[i]);
      drive_e(BASE - {8'h00, sv[i]});
      cyc(3);
      cmp(touch_out, 1'b0);
      drive_e(BASE - {8'h00, sv[i]} - 16'h0001);
      cyc(3);
      cmp(touch_out, 1'b1);
      drive_e(BASE);
      cyc(3);
    end
    host_i.wr(8'h09, 8'h5a);
    host_i.rd(8'h09, rd);
    cmp(rd, 8'h5a);
    host_i.wr(8'h09, 8'h00);
    host_i.wr(8'h07, 8'hff);
    host_i.rd(8'h07, rd);
    cmp(rd, 8'h07);
    host_i.wr(8'h0b, 8'h55);
    host_i.rd_open(8'h0b);
    for (int i = 0; i <= DL; i++) begin
      host_i.recv(i == DL, rd);
      ex = (i < DL) ? TXT[8*(DL-i)-1 -: 8] : 8'h00;
      cmp(rd, ex);
    end
    host_i.stop;
    // every sounder setting, with bus traffic during the click
    for (int c = 0; c < 8; c++) begin
      host_i.wr(8'h07, c[7:0]);
      e = c[0] ? (c[2] ? LONG : SHORT) / (2 * (c[1] ? HIGHH : LOWH)) : 0;
      drive_e(BASE - 16'h0020);
      n = 0;
      bp = 1'b0;
      fork
        repeat (600) begin
          @(negedge clk_sys);
          if (buzzer_out === 1'b1 && bp === 1'b0) n++;
          bp = buzzer_out;
        end
        host_i.rd(8'h04, rd);
      join
      cmp(rd, 8'h0f);
      cmp(n[15:0], e[15:0]);
      drive_e(BASE);
      cyc(5);
    end
    host_i.wr(8'h07, 8'h00);
    @(posedge clk_sys);
    auto_recal_on <= 1'b1;
    drive_e(BASE - 16'h0020);
    tick(300);
    cyc(3);
    cmp(touch_out, 1'b1);
    cmp(baseline_out, BASE);
    drive_e(BASE);
    tick(2);
    host_i.wr(8'h09, 8'h01);
    drive_e(BASE - 16'h0020);
    cyc(3);
    tick(127);
    cyc(3);
    cmp(touch_out, 1'b1);
    tick(1);
    cyc(3);
    cmp(touch_out, 1'b0);
    cmp(baseline_out, BASE - 16'h0020);
    tick(8);
    cyc(3);
    cmp(touch_out, 1'b0);
    drive_e(BASE - 16'h0018);
    tick(64);
    cyc(3);
    cmp(touch_out, 1'b0);
    cmp(baseline_out, BASE - 16'h0018);
    tally_and_finish;
  end
endmodule
`default_nettype wire
